// ---- inc/dar_pkg.sv ----
// shared offsets, field layouts, reset values and carriers of the attribute bank
package dar_pkg;
	localparam int DAR_AW = 12;
	localparam int DAR_DW = 32;
	localparam logic [11:0] DAR_OFS_LPAT_POS = 12'h3E0;
	localparam logic [11:0] DAR_OFS_TILE = 12'h468;
	localparam logic [11:0] DAR_OFS_TBO = 12'h46C;
	localparam logic [11:0] DAR_OFS_SHO = 12'h470;
	localparam logic [11:0] DAR_OFS_AMB = 12'h474;
	localparam logic [11:0] DAR_OFS_FG = 12'h480;
	localparam logic [11:0] DAR_OFS_BG = 12'h484;
	localparam logic [11:0] DAR_OFS_ALF = 12'h488;
	localparam logic [11:0] DAR_OFS_LPAT = 12'h48C;
	localparam logic [11:0] DAR_OFS_TBC = 12'h494;
	localparam int DAR_TILE_W_LSB = 0;
	localparam int DAR_TILE_H_LSB = 16;
	localparam int DAR_TILE_FLD_W = 7;
	localparam logic [31:0] DAR_TILE_MASK = 32'h007F_007F;
	localparam logic [31:0] DAR_TILE_RST = 32'h0040_0040;
	localparam logic [31:0] DAR_TBO_MASK = 32'h0000_FFFE;
	localparam logic [31:0] DAR_AMB_MASK = 32'hFFFF_FFF0;
	localparam logic [31:0] DAR_ALF_MASK = 32'h0000_00FF;
	localparam logic [31:0] DAR_ZERO32 = 32'h0000_0000;
	localparam logic [31:0] DAR_IDX8_MASK = 32'h0000_00FF;
	localparam logic [31:0] DAR_D15_MASK = 32'h0000_7FFF;
	localparam logic [31:0] DAR_D16_MASK = 32'h0000_FFFF;
	localparam logic [31:0] DAR_BG24_MASK = 32'h7FFF_FFFF;
	localparam logic [31:0] DAR_PAT24_MASK = 32'h00FF_FFFF;
	localparam int DAR_BT_BIT_LO = 15;
	localparam int DAR_BT_BIT_HI = 31;
	localparam int DAR_GOURAUD_MSB = 15;
	localparam logic [4:0] DAR_LPAT_POS_RST = 5'h1F;
	localparam logic [4:0] DAR_LPAT_TOP32 = 5'h1F;
	localparam logic [4:0] DAR_LPAT_TOP24 = 5'h17;
	// triangle setup word indices, byte offset is four times the index
	localparam int DAR_TRI_WORDS = 9;
	localparam logic [3:0] DAR_TRI_START_Y = 4'h0;
	localparam logic [3:0] DAR_TRI_LONG_X = 4'h1;
	localparam logic [3:0] DAR_TRI_LONG_SLOPE = 4'h2;
	localparam logic [3:0] DAR_TRI_UPPER_X = 4'h3;
	localparam logic [3:0] DAR_TRI_UPPER_SLOPE = 4'h4;
	localparam logic [3:0] DAR_TRI_LOWER_X = 4'h5;
	localparam logic [3:0] DAR_TRI_LOWER_SLOPE = 4'h6;
	localparam logic [3:0] DAR_TRI_USN = 4'h7;
	localparam logic [3:0] DAR_TRI_LSN = 4'h8;
	typedef enum logic [1:0] {
		DAR_CM8 = 2'b00,
		DAR_CM16 = 2'b01,
		DAR_CM24 = 2'b10
	} dar_cmode_e;
	typedef struct packed {
		logic valid;
		logic pat_bit;
		logic write_en;
		logic [31:0] colour;
	} dar_pix_s;
	typedef struct packed {
		logic [31:0] fg;
		logic [31:0] bg;
		logic bg_transparent;
		logic fg_gouraud_msb;
		logic [31:0] border;
	} dar_colour_s;
endpackage

// ---- rtl/dar_tri_mem.sv ----
// small word store for triangle setup parameters with registered read data
`timescale 1ns/10ps
module dar_tri_mem #(
	parameter int WORDS = 9,
	parameter int DW = 32,
	parameter int AW = 4
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_idx,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_idx,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [WORDS];

	// indices at or beyond the word count are dropped, reads of them give zero
	always_ff @(posedge clk_sys) begin
		if (wr_en && (int'(wr_idx) < WORDS)) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_data <= '0;
		end else if (int'(rd_idx) < WORDS) begin
			rd_data <= mem[rd_idx];
		end else begin
			rd_data <= '0;
		end
	end
endmodule

// ---- rtl/dar_attr_regs.sv ----
// drawing attribute register bank with line pattern stepping and triangle setup store
`timescale 1ns/10ps
module dar_attr_regs
	import dar_pkg::*;
#(
	parameter int TRI_WORDS = DAR_TRI_WORDS
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DAR_AW-1:0] reg_addr,
	input wire logic [DAR_DW-1:0] reg_wdata,
	output logic [DAR_DW-1:0] reg_rdata,
	output logic reg_ack,
	input wire logic cmd_tri_wr,
	input wire logic [3:0] cmd_tri_idx,
	input wire logic [DAR_DW-1:0] cmd_tri_wdata,
	input wire logic [3:0] tri_rd_idx,
	output logic [DAR_DW-1:0] tri_rd_data,
	input wire dar_cmode_e colour_mode,
	input wire logic pat_len24,
	input wire logic line_pixel,
	input wire logic bmp_pixel,
	input wire logic bmp_bit,
	input wire logic prim_body_start,
	input wire logic prim_shadow_start,
	input wire logic signed [11:0] shadow_dx,
	input wire logic signed [11:0] shadow_dy,
	input wire logic [11:0] draw_stride,
	output dar_pix_s pix_out,
	output dar_colour_s colours,
	output logic [6:0] tile_width,
	output logic [6:0] tile_height,
	output logic tile_size_ok,
	output logic [15:0] tex_buf_offset,
	output logic [31:0] shadow_ofs,
	output logic [31:0] alpha_base,
	output logic [7:0] alpha_coef,
	output logic [4:0] pattern_pos,
	output logic upper_part_en,
	output logic lower_part_en
);
	logic [31:0] tile_r;
	logic [31:0] tbo_r;
	logic [31:0] sho_r;
	logic [31:0] amb_r;
	logic [31:0] fg_r;
	logic [31:0] bg_r;
	logic [31:0] alf_r;
	logic [31:0] lpat_r;
	logic [31:0] tbc_r;
	logic [4:0] pos_r;
	logic [4:0] pos_nxt;
	logic [31:0] rdata_nxt;
	logic usn_nz_r;
	logic lsn_nz_r;
	logic wr_pos;
	logic [31:0] pat_eff;
	logic cur_bit;
	logic bg_transp;
	logic [31:0] fg_eff;
	logic [31:0] bg_eff;
	logic signed [24:0] sh_prod;
	logic [31:0] sh_calc;

	function automatic logic tile_pow2(input logic [6:0] v);
		return (v == 7'h04) || (v == 7'h08) || (v == 7'h10) || (v == 7'h20) || (v == 7'h40);
	endfunction

	function automatic logic [31:0] colour_fmt(input dar_cmode_e m, input logic [31:0] v,
		input logic [31:0] m16);
		case (m)
			DAR_CM8: colour_fmt = v & DAR_IDX8_MASK;
			DAR_CM16: colour_fmt = v & m16;
			DAR_CM24: colour_fmt = v;
			default: colour_fmt = v & m16;
		endcase
	endfunction

	function automatic logic wr_hit(input logic w, input logic [11:0] a, input logic [11:0] o);
		return w && (a == o);
	endfunction

	assign wr_pos = wr_hit(reg_wr, reg_addr, DAR_OFS_LPAT_POS);

	// only the 0x3E0..0x494 window is decoded, the triangle words are not reachable here
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tile_r <= DAR_TILE_RST;
			tbo_r <= DAR_ZERO32;
			amb_r <= DAR_ZERO32;
			fg_r <= DAR_ZERO32;
			bg_r <= DAR_ZERO32;
			alf_r <= DAR_ZERO32;
			lpat_r <= DAR_ZERO32;
			tbc_r <= DAR_ZERO32;
		end else if (reg_wr) begin
			case (reg_addr)
				DAR_OFS_TILE: tile_r <= reg_wdata & DAR_TILE_MASK;
				DAR_OFS_TBO: tbo_r <= reg_wdata & DAR_TBO_MASK;
				DAR_OFS_AMB: amb_r <= reg_wdata & DAR_AMB_MASK;
				DAR_OFS_FG: fg_r <= reg_wdata;
				DAR_OFS_BG: bg_r <= reg_wdata;
				DAR_OFS_ALF: alf_r <= reg_wdata & DAR_ALF_MASK;
				DAR_OFS_LPAT: lpat_r <= reg_wdata;
				DAR_OFS_TBC: tbc_r <= reg_wdata;
				default: tile_r <= tile_r;
			endcase
		end
	end

	// shadow offset is loaded by hardware at each primitive start; software may also write it
	assign sh_prod = shadow_dy * $signed({1'b0, draw_stride});
	assign sh_calc = {{7{sh_prod[24]}}, sh_prod} + {{20{shadow_dx[11]}}, shadow_dx};

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sho_r <= DAR_ZERO32;
		end else if (prim_body_start) begin
			sho_r <= DAR_ZERO32;
		end else if (prim_shadow_start) begin
			sho_r <= sh_calc;
		end else if (wr_hit(reg_wr, reg_addr, DAR_OFS_SHO)) begin
			sho_r <= reg_wdata;
		end
	end

	// software write wins over a pixel step so a new start position is never skipped
	always_comb begin
		pos_nxt = pos_r;
		if (wr_pos) begin
			pos_nxt = reg_wdata[4:0];
		end else if (line_pixel) begin
			if (pos_r == 5'h00) begin
				pos_nxt = pat_len24 ? DAR_LPAT_TOP24 : DAR_LPAT_TOP32;
			end else begin
				pos_nxt = pos_r - 5'h01;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pos_r <= DAR_LPAT_POS_RST;
		end else begin
			pos_r <= pos_nxt;
		end
	end

	// with 24-bit repeat a pointer left above 23 by software selects a zero bit
	assign pat_eff = pat_len24 ? (lpat_r & DAR_PAT24_MASK) : lpat_r;
	assign cur_bit = pat_eff[pos_r];
	assign bg_transp = (colour_mode == DAR_CM24) ? bg_r[DAR_BT_BIT_HI] : bg_r[DAR_BT_BIT_LO];
	assign fg_eff = colour_fmt(colour_mode, fg_r, DAR_D16_MASK);
	assign bg_eff = colour_fmt(colour_mode, bg_r,
		(colour_mode == DAR_CM24) ? DAR_BG24_MASK : DAR_D15_MASK);

	// one pixel result per strobe; broken-line pixels take priority over bitmap pixels
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pix_out <= '0;
		end else if (line_pixel) begin
			pix_out.valid <= 1'b1;
			pix_out.pat_bit <= cur_bit;
			pix_out.colour <= cur_bit ? fg_eff : bg_eff;
			pix_out.write_en <= cur_bit || !bg_transp;
		end else if (bmp_pixel) begin
			pix_out.valid <= 1'b1;
			pix_out.pat_bit <= bmp_bit;
			pix_out.colour <= bmp_bit ? fg_eff : bg_eff;
			pix_out.write_en <= bmp_bit || !bg_transp;
		end else begin
			pix_out <= '0;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			colours <= '0;
		end else begin
			colours.fg <= fg_eff;
			colours.bg <= bg_eff;
			colours.bg_transparent <= bg_transp;
			colours.fg_gouraud_msb <= fg_r[DAR_GOURAUD_MSB];
			colours.border <= colour_fmt(colour_mode, tbc_r, DAR_D16_MASK);
		end
	end

	// out-of-range tile codes are flagged, the rasteriser treats them as disabled
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tile_size_ok <= 1'b0;
		end else begin
			tile_size_ok <= tile_pow2(tile_r[DAR_TILE_W_LSB +: DAR_TILE_FLD_W])
				&& tile_pow2(tile_r[DAR_TILE_H_LSB +: DAR_TILE_FLD_W]);
		end
	end

	assign tile_width = tile_r[DAR_TILE_W_LSB +: DAR_TILE_FLD_W];
	assign tile_height = tile_r[DAR_TILE_H_LSB +: DAR_TILE_FLD_W];
	assign tex_buf_offset = tbo_r[15:0];
	assign shadow_ofs = sho_r;
	assign alpha_base = amb_r;
	assign alpha_coef = alf_r[7:0];
	assign pattern_pos = pos_r;

	// span counts are shadowed here so the part enables need no memory read
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			usn_nz_r <= 1'b0;
			lsn_nz_r <= 1'b0;
		end else if (cmd_tri_wr) begin
			if (cmd_tri_idx == DAR_TRI_USN) begin
				usn_nz_r <= (cmd_tri_wdata != DAR_ZERO32);
			end
			if (cmd_tri_idx == DAR_TRI_LSN) begin
				lsn_nz_r <= (cmd_tri_wdata != DAR_ZERO32);
			end
		end
	end

	assign upper_part_en = usn_nz_r;
	assign lower_part_en = lsn_nz_r;

	// only the drawing command port writes the triangle store
	dar_tri_mem #(
		.WORDS(TRI_WORDS),
		.DW(DAR_DW),
		.AW(4)
	) u_tri_mem (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.wr_en(cmd_tri_wr),
		.wr_idx(cmd_tri_idx),
		.wr_data(cmd_tri_wdata),
		.rd_idx(tri_rd_idx),
		.rd_data(tri_rd_data)
	);

	always_comb begin
		case (reg_addr)
			DAR_OFS_LPAT_POS: rdata_nxt = {27'h0, pos_r};
			DAR_OFS_TILE: rdata_nxt = tile_r;
			DAR_OFS_TBO: rdata_nxt = tbo_r;
			DAR_OFS_SHO: rdata_nxt = sho_r;
			DAR_OFS_AMB: rdata_nxt = amb_r;
			DAR_OFS_FG: rdata_nxt = fg_r;
			DAR_OFS_BG: rdata_nxt = bg_r;
			DAR_OFS_ALF: rdata_nxt = alf_r;
			DAR_OFS_LPAT: rdata_nxt = lpat_r;
			DAR_OFS_TBC: rdata_nxt = tbc_r;
			default: rdata_nxt = DAR_ZERO32;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= DAR_ZERO32;
			reg_ack <= 1'b0;
		end else begin
			reg_ack <= reg_wr || reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

	property p_ptr_dec;
		@(posedge clk_sys) disable iff (!nrst)
		line_pixel && !wr_pos && (pos_r != 5'h00) |=> pos_r == $past(pos_r) - 5'h01;
	endproperty
	a_ptr_dec: assert property (p_ptr_dec) else $error("pointer did not step down");

	property p_wrap32;
		@(posedge clk_sys) disable iff (!nrst)
		line_pixel && !wr_pos && (pos_r == 5'h00) && !pat_len24 |=> pos_r == 5'h1F;
	endproperty
	a_wrap32: assert property (p_wrap32) else $error("32-bit wrap wrong");

	property p_wrap24;
		@(posedge clk_sys) disable iff (!nrst)
		line_pixel && !wr_pos && (pos_r == 5'h00) && pat_len24 |=> pos_r == 5'h17;
	endproperty
	a_wrap24: assert property (p_wrap24) else $error("24-bit wrap wrong");

	property p_ptr_hold;
		@(posedge clk_sys) disable iff (!nrst)
		!line_pixel && !wr_pos |=> $stable(pos_r);
	endproperty
	a_ptr_hold: assert property (p_ptr_hold) else $error("pointer moved without cause");

	property p_ptr_write;
		@(posedge clk_sys) disable iff (!nrst)
		wr_pos |=> pos_r == $past(reg_wdata[4:0]);
	endproperty
	a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");

	property p_line_colour;
		@(posedge clk_sys) disable iff (!nrst)
		line_pixel |=> pix_out.valid && (pix_out.colour == ($past(cur_bit) ? $past(fg_eff)
			: $past(bg_eff)));
	endproperty
	a_line_colour: assert property (p_line_colour) else $error("line pixel colour wrong");

	property p_bg_transp;
		@(posedge clk_sys) disable iff (!nrst)
		(line_pixel || bmp_pixel) && bg_transp |=> pix_out.write_en == pix_out.pat_bit;
	endproperty
	a_bg_transp: assert property (p_bg_transp) else $error("transparent bg written");

	property p_shadow_body;
		@(posedge clk_sys) disable iff (!nrst)
		prim_body_start |=> shadow_ofs == DAR_ZERO32 ##1 ($past(prim_shadow_start)
			|| $stable(shadow_ofs) || $past(reg_wr && (reg_addr == DAR_OFS_SHO)));
	endproperty
	a_shadow_body: assert property (p_shadow_body) else $error("body shadow offset not 0");

	property p_tbo_lsb;
		@(posedge clk_sys) disable iff (!nrst)
		reg_wr && (reg_addr == DAR_OFS_TBO) |=> tex_buf_offset == ($past(reg_wdata[15:0]) & 16'hFFFE);
	endproperty
	a_tbo_lsb: assert property (p_tbo_lsb) else $error("texture offset wrong");

	property p_span_skip;
		@(posedge clk_sys) disable iff (!nrst)
		cmd_tri_wr && (cmd_tri_idx == DAR_TRI_USN) |=> upper_part_en == ($past(cmd_tri_wdata) != 0);
	endproperty
	a_span_skip: assert property (p_span_skip) else $error("upper part enable wrong");

	property p_gouraud;
		@(posedge clk_sys) disable iff (!nrst)
		1'b1 |=> colours.fg_gouraud_msb == $past(fg_r[DAR_GOURAUD_MSB]);
	endproperty
	a_gouraud: assert property (p_gouraud) else $error("gouraud msb not carried");

	c_wrap24: cover property (@(posedge clk_sys) disable iff (!nrst)
		line_pixel && pat_len24 && (pos_r == 5'h00));
	c_transp: cover property (@(posedge clk_sys) disable iff (!nrst)
		pix_out.valid && !pix_out.write_en);
	c_shadow: cover property (@(posedge clk_sys) disable iff (!nrst)
		prim_body_start ##[1:20] prim_shadow_start);
	c_ptr_write_step: cover property (@(posedge clk_sys) disable iff (!nrst) wr_pos && line_pixel);
endmodule

// ---- sim/dar_host_model.sv ----
// host cpu and drawing command processor model for the attribute bank
`timescale 1ns/10ps
module dar_host_model
	import dar_pkg::*;
(
	input wire logic clk_sys,
	output logic reg_wr,
	output logic reg_rd,
	output logic [DAR_AW-1:0] reg_addr,
	output logic [DAR_DW-1:0] reg_wdata,
	input wire logic [DAR_DW-1:0] reg_rdata,
	input wire logic reg_ack,
	output logic cmd_tri_wr,
	output logic [3:0] cmd_tri_idx,
	output logic [DAR_DW-1:0] cmd_tri_wdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0000_0000;
		cmd_tri_wr = 1'b0;
		cmd_tri_idx = 4'h0;
		cmd_tri_wdata = 32'h0000_0000;
	end
	// released address and data lines flip to the inverse so a stale value is never mistaken for data
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
		q = (reg_ack === 1'b1) ? reg_rdata : 32'hxxxx_xxxx;
	endtask
	// sizes given as powers of two 2..6, so both fields stay one-hot
	task automatic tile_set(input int wl, input int hl);
		logic [31:0] q;
		acc(1'b1, DAR_OFS_TILE, (32'h1 << wl) | (32'h1 << (hl + 16)), q);
	endtask
	task automatic tri_wr(input logic [3:0] i, input logic [31:0] d);
		@(posedge clk_sys);
		cmd_tri_wr <= 1'b1;
		cmd_tri_idx <= i;
		cmd_tri_wdata <= d;
		@(posedge clk_sys);
		cmd_tri_wr <= 1'b0;
		cmd_tri_wdata <= ~d;
	endtask
endmodule

// ---- sim/test_dar_attr_regs.sv ----
// self-checking bench for the drawing attribute bank
`timescale 1ns/10ps
module test_dar_attr_regs;
	import dar_pkg::*;
	logic clk_sys, nrst, reg_wr, reg_rd, reg_ack, cmd_tri_wr;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, cmd_tri_wdata, tri_rd_data;
	logic [3:0] cmd_tri_idx, tri_rd_idx;
	dar_cmode_e colour_mode;
	logic pat_len24, line_pixel, bmp_pixel, bmp_bit, prim_body_start, prim_shadow_start;
	logic signed [11:0] shadow_dx, shadow_dy;
	logic [11:0] draw_stride;
	dar_pix_s pix_out;
	dar_colour_s colours;
	logic [6:0] tile_width, tile_height;
	logic tile_size_ok, upper_part_en, lower_part_en;
	logic [15:0] tex_buf_offset;
	logic [31:0] shadow_ofs, alpha_base;
	logic [7:0] alpha_coef;
	logic [4:0] pattern_pos;
	int num_errors = 0;
	int compares = 0;
	int cyc = 0;
	dar_attr_regs uut (.*);
	dar_host_model host (.*);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// a hang is cut after far more cycles than the scenarios need
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		host.acc(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] q;
		host.acc(1'b0, a, 32'h0, q);
		chk("reg_rdata", e, q);
	endtask
	task automatic pix(input logic ln, input logic b, input logic [31:0] c, input logic we);
		@(posedge clk_sys);
		line_pixel <= ln;
		bmp_pixel <= !ln;
		bmp_bit <= b;
		@(posedge clk_sys);
		line_pixel <= 1'b0;
		bmp_pixel <= 1'b0;
		#1;
		chk("pix_valid", 32'h1, 32'(pix_out.valid));
		chk("pix_bit", 32'(b), 32'(pix_out.pat_bit));
		chk("pix_colour", c, pix_out.colour);
		chk("pix_we", 32'(we), 32'(pix_out.write_en));
	endtask
	task automatic t_reset();
		rd(DAR_OFS_LPAT_POS, 32'h0000_001F);
		rd(DAR_OFS_TILE, DAR_TILE_RST);
		rd(DAR_OFS_ALF, 32'h0000_0000);
		rd(DAR_OFS_FG, 32'h0000_0000);
		chk("tile_ok", 32'h1, 32'(tile_size_ok));
	endtask
	task automatic t_regs();
		wr(DAR_OFS_TBO, 32'hABCD_1236);
		rd(DAR_OFS_TBO, 32'h0000_1236);
		chk("tbo", 32'h1236, 32'(tex_buf_offset));
		wr(DAR_OFS_ALF, 32'hFFFF_FFFF);
		rd(DAR_OFS_ALF, 32'h0000_00FF);
		chk("alpha_coef", 32'hFF, 32'(alpha_coef));
		wr(DAR_OFS_AMB, 32'hFFFF_FFFF);
		rd(DAR_OFS_AMB, 32'hFFFF_FFF0);
		chk("alpha_base", 32'hFFFF_FFF0, alpha_base);
		wr(12'h01C, 32'h0000_0005);
		rd(12'h01C, 32'h0000_0000);
		host.tile_set(3, 2);
		rd(DAR_OFS_TILE, 32'h0004_0008);
		chk("tile_w", 32'h8, 32'(tile_width));
		chk("tile_h", 32'h4, 32'(tile_height));
		chk("tile_ok", 32'h1, 32'(tile_size_ok));
		// two bits set in the width field is a disabled setting
		wr(DAR_OFS_TILE, 32'h0004_000C);
		rd(DAR_OFS_TILE, 32'h0004_000C);
		chk("tile_bad", 32'h0, 32'(tile_size_ok));
	endtask
	task automatic t_line();
		wr(DAR_OFS_FG, 32'h1234_5678);
		wr(DAR_OFS_BG, 32'h0000_0A22);
		wr(DAR_OFS_LPAT, 32'hA080_0001);
		pix(1'b1, 1'b1, 32'h78, 1'b1);
		chk("fg8", 32'h78, colours.fg);
		pix(1'b1, 1'b0, 32'h22, 1'b1);
		pix(1'b1, 1'b1, 32'h78, 1'b1);
		chk("pos", 32'd28, 32'(pattern_pos));
		wr(DAR_OFS_BG, 32'h0000_8A22);
		pix(1'b1, 1'b0, 32'h22, 1'b0);
		chk("bg_transp", 32'h1, 32'(colours.bg_transparent));
		pix(1'b0, 1'b0, 32'h22, 1'b0);
		pix(1'b0, 1'b1, 32'h78, 1'b1);
		chk("pos_held", 32'd27, 32'(pattern_pos));
		wr(DAR_OFS_LPAT_POS, 32'h0000_0000);
		rd(DAR_OFS_LPAT_POS, 32'h0000_0000);
		pix(1'b1, 1'b1, 32'h78, 1'b1);
		chk("pos_wrap", 32'd31, 32'(pattern_pos));
		@(posedge clk_sys);
		colour_mode <= DAR_CM16;
		wr(DAR_OFS_FG, 32'h1234_8678);
		// the colour carrier is registered, so it shows the new value one edge later
		@(posedge clk_sys);
		#1;
		chk("gouraud_msb", 32'h1, 32'(colours.fg_gouraud_msb));
		chk("fg16", 32'h0000_8678, colours.fg);
		pix(1'b1, 1'b1, 32'h8678, 1'b1);
		@(posedge clk_sys);
		colour_mode <= DAR_CM24;
		pat_len24 <= 1'b1;
		wr(DAR_OFS_TBC, 32'h1234_5678);
		@(posedge clk_sys);
		#1;
		chk("border", 32'h1234_5678, colours.border);
		chk("bg24", 32'h0000_8A22, colours.bg);
		chk("bg_opaque24", 32'h0, 32'(colours.bg_transparent));
		wr(DAR_OFS_LPAT_POS, 32'h0000_0000);
		pix(1'b1, 1'b1, 32'h1234_8678, 1'b1);
		chk("pos24", 32'd23, 32'(pattern_pos));
		pix(1'b1, 1'b1, 32'h1234_8678, 1'b1);
		wr(DAR_OFS_LPAT_POS, 32'h0000_0015);
		pix(1'b1, 1'b0, 32'h0000_8A22, 1'b1);
	endtask
	task automatic t_shadow_tri();
		@(posedge clk_sys);
		shadow_dx <= -12'sd3;
		shadow_dy <= 12'sd2;
		draw_stride <= 12'd100;
		prim_shadow_start <= 1'b1;
		@(posedge clk_sys);
		prim_shadow_start <= 1'b0;
		#1;
		chk("shadow", 32'd197, shadow_ofs);
		@(posedge clk_sys);
		prim_body_start <= 1'b1;
		@(posedge clk_sys);
		prim_body_start <= 1'b0;
		#1;
		chk("body", 32'h0, shadow_ofs);
		host.tri_wr(4'h7, 32'h0000_0005);
		host.tri_wr(4'h8, 32'h0000_0000);
		host.tri_wr(4'h3, 32'hCAFE_0001);
		wr(12'h00C, 32'h0000_0000);
		rd(12'h00C, 32'h0000_0000);
		@(posedge clk_sys);
		tri_rd_idx <= 4'h3;
		repeat (2) @(posedge clk_sys);
		#1;
		chk("tri_rd", 32'hCAFE_0001, tri_rd_data);
		chk("upper_en", 32'h1, 32'(upper_part_en));
		chk("lower_en", 32'h0, 32'(lower_part_en));
		host.tri_wr(4'h7, 32'h0000_0000);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("upper_off", 32'h0, 32'(upper_part_en));
	endtask
	initial begin
		nrst = 1'b0;
		tri_rd_idx = 4'h0;
		colour_mode = DAR_CM8;
		pat_len24 = 1'b0;
		line_pixel = 1'b0;
		bmp_pixel = 1'b0;
		bmp_bit = 1'b0;
		prim_body_start = 1'b0;
		prim_shadow_start = 1'b0;
		shadow_dx = 12'sd0;
		shadow_dy = 12'sd0;
		draw_stride = 12'h000;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_regs();
		t_line();
		t_shadow_tri();
		tally_and_finish();
	end
endmodule
